// file: l1_icache_control_config.sv
// Instruction cache control/status register, read-only configuration words,
// error injection and error action steering, and data miss drain ordering.
// Assumes the core issues register moves on clk_sys and that array, lock
// and buffer signals come from logic on the same clock.
`timescale 1ns/1ps

// Behaviour
// - Report errors only while checking is enabled
// - Parity type injection inverts each byte parity
// - EDC type injection flips top two checks
// - Injection ignores checking enable; reporting masked
// - Detection type 00 parity, 01 EDC
// - Sticky unable-to-lock flag, cleared writing zero
// - Sticky lock overflow flag, cleared writing zero
// - Flash clear starts on one, self-clears
// - Flash clear takes 134 cycles, enable ignored
// - Overflow allocate lets lock replace locked line
// - Error action: 00 machine check, 01 correct
// - Tag/lock errors corrected or invalidated per type
// - Data errors repaired by line reload
// - Sticky aborted flag on early operation end
// - Invalidate-all starts on one, self-clears
// - Invalidate takes 134 cycles, writes type checks
// - Enable clear skips instruction lookups only
// - Data cache configuration word fixed values
// - Instruction cache configuration word fixed values
// - Data miss waits for empty push/store buffers
// - Reset clears the cache enable
module l1_icache_control_config
    import l1_cache_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Register move port
    input wire logic [9:0] spr_num,
    input wire logic spr_wr,
    input wire logic [31:0] spr_wdata,
    input wire logic spr_rd,
    output logic [31:0] spr_rdata,
    output logic spr_rvalid,
    // Instruction cache array side
    input wire logic fill_wr,
    output logic [7:0] fill_par_invert,
    output logic [1:0] fill_chk_invert,
    output logic icache_lookup_en,
    output logic [1:0] chk_type,
    output logic inval_busy,
    output logic inval_done,
    output logic flash_busy,
    output logic flash_done,
    input wire logic op_abort,
    // Locking
    input wire logic lock_fail,
    input wire logic lock_overflow,
    output logic ovf_replace_locked,
    // Detected array errors
    input wire logic err_det,
    input wire logic [1:0] err_site,
    input wire logic err_multi,
    input wire logic err_line_locked,
    output logic mchk_req,
    output logic err_correct,
    output logic line_inval_req,
    output logic line_reload_req,
    // Data cache miss ordering
    input wire logic dmiss_req,
    input wire logic push_buf_empty,
    input wire logic store_buf_empty,
    output logic dmiss_go,
    output logic drain_req
);

    // Reset release synchroniser; only the second stage is used
    logic rst_meta_r, rst_n_s;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s <= rst_meta_r;
        end
    end

    // Software-owned control fields
    logic check_en_r, check_en_nxt;
    logic inject_r, inject_nxt;
    logic [1:0] dtype_r, dtype_nxt;
    logic ovf_alloc_r, ovf_alloc_nxt;
    logic [1:0] action_r, action_nxt;
    logic enable_r, enable_nxt;
    // Hardware-set sticky flags
    logic unable_r, unable_nxt;
    logic overflow_r, overflow_nxt;
    logic aborted_r, aborted_nxt;
    // Read port
    logic [31:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    // Error outputs
    logic mchk_r, mchk_nxt;
    logic correct_r, correct_nxt;
    logic inval_line_r, inval_line_nxt;
    logic reload_r, reload_nxt;
    // Injection masks
    logic [7:0] par_inv_r, par_inv_nxt;
    logic [1:0] chk_inv_r, chk_inv_nxt;

    // Decoded register move
    logic csr_wr;
    logic inval_start, flash_start;
    logic inval_abort_ev, flash_abort_ev;
    logic [31:0] csr_view;

    assign csr_wr = spr_wr && (spr_num == SPR_ICACHE_CSR);

    // start invalidate: a one starts it, a zero while busy is ignored
    // restart guard: a one while busy is undefined; treated as no-op
    assign inval_start = csr_wr && spr_wdata[POS_INVAL] && !inval_busy;
    // start flash clear: same start and ignore semantics
    assign flash_start = csr_wr && spr_wdata[POS_FLASH] && !flash_busy;

    // invalidate sweep: fixed length, independent of the enable
    cache_op_timer #(
        .CYCLES(OP_CYCLES)
    ) u_inval (
        .clk_sys(clk_sys),
        .rst_n(rst_n_s),
        .ce(ce),
        .start(inval_start),
        .abort(op_abort),
        .busy(inval_busy),
        .done(inval_done),
        .aborted(inval_abort_ev)
    );

    // lock flash clear: fixed length, independent of the enable
    cache_op_timer #(
        .CYCLES(OP_CYCLES)
    ) u_flash (
        .clk_sys(clk_sys),
        .rst_n(rst_n_s),
        .ce(ce),
        .start(flash_start),
        .abort(op_abort),
        .busy(flash_busy),
        .done(flash_done),
        .aborted(flash_abort_ev)
    );

    // Live view of the control/status word; reserved bits read as zero
    always_comb begin
        csr_view = 32'h0000_0000;
        csr_view[POS_CHECK_EN] = check_en_r;
        csr_view[POS_INJECT] = inject_r;
        csr_view[POS_DTYPE_LO +: 2] = dtype_r;
        csr_view[POS_UNABLE] = unable_r;
        csr_view[POS_OVERFLOW] = overflow_r;
        // Operation bits read back as one until the sweep ends
        csr_view[POS_FLASH] = flash_busy;
        csr_view[POS_OVF_ALLOC] = ovf_alloc_r;
        csr_view[POS_ACTION_LO +: 2] = action_r;
        csr_view[POS_ABORTED] = aborted_r;
        csr_view[POS_INVAL] = inval_busy;
        csr_view[POS_ENABLE] = enable_r;
    end

    // Control fields and sticky flags
    always_comb begin
        check_en_nxt = check_en_r;
        inject_nxt = inject_r;
        dtype_nxt = dtype_r;
        ovf_alloc_nxt = ovf_alloc_r;
        action_nxt = action_r;
        enable_nxt = enable_r;
        unable_nxt = unable_r;
        overflow_nxt = overflow_r;
        aborted_nxt = aborted_r;
        if (csr_wr) begin
            check_en_nxt = spr_wdata[POS_CHECK_EN];
            inject_nxt = spr_wdata[POS_INJECT];
            // detection type: stored as written, 1x kept but acts as parity
            dtype_nxt = spr_wdata[POS_DTYPE_LO +: 2];
            ovf_alloc_nxt = spr_wdata[POS_OVF_ALLOC];
            action_nxt = spr_wdata[POS_ACTION_LO +: 2];
            enable_nxt = spr_wdata[POS_ENABLE];
            // Writing zero clears a sticky flag, writing one leaves it
            unable_nxt = unable_r && spr_wdata[POS_UNABLE];
            overflow_nxt = overflow_r && spr_wdata[POS_OVERFLOW];
            aborted_nxt = aborted_r && spr_wdata[POS_ABORTED];
        end
        // unable-to-lock: a set in the clear cycle wins
        if (lock_fail && !lock_overflow) begin
            unable_nxt = 1'b1;
        end
        // overflow flag: a set in the clear cycle wins
        if (lock_overflow) begin
            overflow_nxt = 1'b1;
        end
        // aborted flag: either sweep ending early sets it
        if (inval_abort_ev || flash_abort_ev) begin
            aborted_nxt = 1'b1;
        end
    end

    // Register read port: data one cycle after the read strobe
    always_comb begin
        rvalid_nxt = spr_rd;
        rdata_nxt = rdata_r;
        if (spr_rd) begin
            case (spr_num)
                SPR_ICACHE_CSR: rdata_nxt = csr_view;
                SPR_DCACHE_CFG: rdata_nxt = DCACHE_CFG_VALUE;
                SPR_ICACHE_CFG: rdata_nxt = ICACHE_CFG_VALUE;
                // Unmapped numbers read as zero
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Error injection masks applied to linefill writes
    always_comb begin
        par_inv_nxt = 8'h00;
        chk_inv_nxt = 2'h0;
        // injection: does not look at the checking enable
        if (inject_r && fill_wr) begin
            if (dtype_r == DTYPE_EDC) begin
                // double-bit error: two uppermost check bits flipped
                chk_inv_nxt = 2'h3;
            end else begin
                // parity injection: every byte parity bit inverted
                par_inv_nxt = 8'hFF;
            end
        end
    end

    // Error action steering, one cycle after detection
    always_comb begin
        mchk_nxt = 1'b0;
        correct_nxt = 1'b0;
        inval_line_nxt = 1'b0;
        reload_nxt = 1'b0;
        // reporting gate: nothing leaves while checking is off
        if (err_det && check_en_r) begin
            // action select: reserved 1x behaves as machine check
            if (action_r != ACTION_CORRECT) begin
                mchk_nxt = 1'b1;
            end else if (err_site == SITE_DATA) begin
                // data errors: line reloaded in either scheme
                reload_nxt = 1'b1;
            end else if (dtype_r == DTYPE_EDC && !err_multi) begin
                // EDC single-bit tag or lock error corrected
                correct_nxt = 1'b1;
            end else begin
                // multi-bit or parity tag/lock error invalidates
                inval_line_nxt = 1'b1;
                // invalidating a locked line still raises a check
                mchk_nxt = err_line_locked;
            end
        end
    end

    // State registers, all frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            check_en_r <= CSR_RESET[POS_CHECK_EN];
            inject_r <= CSR_RESET[POS_INJECT];
            dtype_r <= CSR_RESET[POS_DTYPE_LO +: 2];
            ovf_alloc_r <= CSR_RESET[POS_OVF_ALLOC];
            action_r <= CSR_RESET[POS_ACTION_LO +: 2];
            enable_r <= CSR_RESET[POS_ENABLE];
            unable_r <= CSR_RESET[POS_UNABLE];
            overflow_r <= CSR_RESET[POS_OVERFLOW];
            aborted_r <= CSR_RESET[POS_ABORTED];
            rdata_r <= 32'h0000_0000;
            rvalid_r <= 1'b0;
            mchk_r <= 1'b0;
            correct_r <= 1'b0;
            inval_line_r <= 1'b0;
            reload_r <= 1'b0;
            par_inv_r <= 8'h00;
            chk_inv_r <= 2'h0;
        end else if (ce) begin
            check_en_r <= check_en_nxt;
            inject_r <= inject_nxt;
            dtype_r <= dtype_nxt;
            ovf_alloc_r <= ovf_alloc_nxt;
            action_r <= action_nxt;
            enable_r <= enable_nxt;
            unable_r <= unable_nxt;
            overflow_r <= overflow_nxt;
            aborted_r <= aborted_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            mchk_r <= mchk_nxt;
            correct_r <= correct_nxt;
            inval_line_r <= inval_line_nxt;
            reload_r <= reload_nxt;
            par_inv_r <= par_inv_nxt;
            chk_inv_r <= chk_inv_nxt;
        end
    end

    assign spr_rdata = rdata_r;
    assign spr_rvalid = rvalid_r;
    assign fill_par_invert = par_inv_r;
    assign fill_chk_invert = chk_inv_r;
    // lookups skipped while disabled; sweeps still run
    assign icache_lookup_en = enable_r;
    // check bits during a sweep follow the current type
    assign chk_type = dtype_r;
    assign ovf_replace_locked = ovf_alloc_r;
    assign mchk_req = mchk_r;
    assign err_correct = correct_r;
    assign line_inval_req = inval_line_r;
    assign line_reload_req = reload_r;

    // miss held until push and store buffers are empty
    assign dmiss_go = dmiss_req && push_buf_empty && store_buf_empty && ce;
    assign drain_req = dmiss_req && !(push_buf_empty && store_buf_empty);

endmodule

// file: l1_cache_pkg.sv
// Shared constants for the level-one cache control and configuration block.
// Assumes one core clock; bit positions are little-endian indices (bit 0 = LSB).
package l1_cache_pkg;

    // Special-register numbers seen on the register move port
    localparam logic [9:0] SPR_ICACHE_CSR = 10'h3F3;
    localparam logic [9:0] SPR_DCACHE_CFG = 10'h3F8;
    localparam logic [9:0] SPR_ICACHE_CFG = 10'h3F9;

    // Control/status field positions (little-endian index)
    localparam int POS_CHECK_EN = 16;
    localparam int POS_INJECT = 15;
    localparam int POS_DTYPE_LO = 12;
    localparam int POS_UNABLE = 10;
    localparam int POS_OVERFLOW = 9;
    localparam int POS_FLASH = 8;
    localparam int POS_OVF_ALLOC = 7;
    localparam int POS_ACTION_LO = 5;
    localparam int POS_ABORTED = 2;
    localparam int POS_INVAL = 1;
    localparam int POS_ENABLE = 0;

    // Detection type and error action encodings
    localparam logic [1:0] DTYPE_PARITY = 2'h0;
    localparam logic [1:0] DTYPE_EDC = 2'h1;
    localparam logic [1:0] ACTION_MCHK = 2'h0;
    localparam logic [1:0] ACTION_CORRECT = 2'h1;

    // Error site encodings reported by the arrays
    localparam logic [1:0] SITE_TAG = 2'h0;
    localparam logic [1:0] SITE_LOCK = 2'h1;
    localparam logic [1:0] SITE_DATA = 2'h2;

    // Values after reset
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;

    // Length of invalidate-all and lock flash clear, in core cycles
    localparam int OP_CYCLES = 134;

    // Read-only configuration words, fields from MSB to LSB
    localparam logic [31:0] DCACHE_CFG_VALUE = {2'h0, 1'h1, 1'h0, 1'h1, 2'h0, 2'h0, 2'h2,
                                                1'h1, 1'h1, 8'h03, 11'h010};
    localparam logic [31:0] ICACHE_CFG_VALUE = {4'h0, 1'h1, 2'h0, 2'h0, 2'h2,
                                                1'h1, 1'h1, 8'h03, 11'h010};

    // Background operation sequencer states, Gray along idle-run-done
    typedef enum logic [1:0] {
        OP_IDLE = 2'h0,
        OP_RUN = 2'h1,
        OP_DONE = 2'h3
    } op_state_t;

endpackage

// file: cache_op_timer.sv
// Background cache operation sequencer: runs a fixed-length sweep.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/1ps
module cache_op_timer
    import l1_cache_pkg::*;
#(
    parameter int CYCLES = OP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic done,
    output logic aborted
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    // Sequencer state and sweep counter
    op_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic abort_r, abort_nxt;

    // Next state: count CYCLES cycles in RUN, then one DONE cycle
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        abort_nxt = 1'b0;
        case (state_r)
            OP_IDLE: begin
                if (start) begin
                    state_nxt = OP_RUN;
                    cnt_nxt = '0;
                end
            end
            OP_RUN: begin
                // An abort ends the sweep early and is flagged once
                if (abort) begin
                    state_nxt = OP_IDLE;
                    abort_nxt = 1'b1;
                end else if (cnt_r == LAST) begin
                    state_nxt = OP_DONE;
                end else begin
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            OP_DONE: begin
                state_nxt = OP_IDLE;
            end
            default: begin
                state_nxt = OP_IDLE;
            end
        endcase
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= OP_IDLE;
            cnt_r <= '0;
            abort_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            abort_r <= abort_nxt;
        end
    end

    assign busy = (state_r == OP_RUN);
    assign done = (state_r == OP_DONE);
    assign aborted = abort_r;
endmodule

// file: l1_cc_asserts.sv
// Port-level checker for the level-one cache control block.
// Assumes it is bound onto l1_icache_control_config, one clock domain.
`timescale 1ns/1ps
module l1_cc_asserts
    import l1_cache_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [9:0] spr_num,
    input wire logic spr_rd,
    input wire logic [31:0] spr_rdata,
    input wire logic spr_rvalid,
    input wire logic fill_wr,
    input wire logic [7:0] fill_par_invert,
    input wire logic [1:0] fill_chk_invert,
    input wire logic [1:0] chk_type,
    input wire logic inval_busy,
    input wire logic inval_done,
    input wire logic flash_busy,
    input wire logic flash_done,
    input wire logic err_det,
    input wire logic [1:0] err_site,
    input wire logic err_multi,
    input wire logic mchk_req,
    input wire logic err_correct,
    input wire logic line_reload_req,
    input wire logic dmiss_req,
    input wire logic push_buf_empty,
    input wire logic store_buf_empty,
    input wire logic dmiss_go
);
    // Busy-cycle counter of the invalidate sweep; 8 bits cover 134
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // Count only enabled cycles, since ce freezes the sweep timer
    always_comb begin
        cnt_nxt = inval_busy ? (cnt_r + {7'h0, ce}) : 8'h00;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // A read move taken, and its answer one cycle later
    sequence s_rd_taken;
        spr_rd && ce;
    endsequence
    sequence s_answer;
        spr_rvalid;
    endsequence

    a_read_answer: assert property (s_rd_taken |=> s_answer)
        else $error("read move not answered");
    a_icfg_value: assert property (s_rd_taken ##0 spr_num == SPR_ICACHE_CFG
        |=> spr_rdata == ICACHE_CFG_VALUE) else $error("icache config word wrong");
    a_dcfg_value: assert property (s_rd_taken ##0 spr_num == SPR_DCACHE_CFG
        |=> spr_rdata == DCACHE_CFG_VALUE) else $error("dcache config word wrong");
    a_par_inject: assert property (fill_par_invert != 8'h00 |-> fill_par_invert == 8'hFF
        && $past(fill_wr) && $past(chk_type) != DTYPE_EDC) else $error("bad parity inject");
    a_edc_inject: assert property (fill_chk_invert != 2'h0 |-> fill_chk_invert == 2'h3
        && $past(fill_wr) && $past(chk_type) == DTYPE_EDC) else $error("bad check inject");
    a_sweep_len: assert property (inval_done |-> cnt_r == OP_CYCLES)
        else $error("invalidate length wrong");
    a_flash_end: assert property (flash_done |-> $past(flash_busy) && !flash_busy)
        else $error("flash done without run");
    a_mchk_cause: assert property (mchk_req |-> $past(err_det))
        else $error("machine check without error");
    a_reload_data: assert property (line_reload_req |-> $past(err_det)
        && $past(err_site) == SITE_DATA) else $error("reload without data error");
    a_edc_correct: assert property (err_correct |-> $past(chk_type) == DTYPE_EDC
        && $past(err_det && !err_multi && err_site != SITE_DATA)) else $error("bad correct");
    a_miss_order: assert property (dmiss_go |-> dmiss_req && push_buf_empty
        && store_buf_empty) else $error("miss went before drain");
endmodule

bind l1_icache_control_config l1_cc_asserts chk (.clk_sys, .rstn, .ce, .spr_num, .spr_rd,
    .spr_rdata, .spr_rvalid, .fill_wr, .fill_par_invert, .fill_chk_invert, .chk_type,
    .inval_busy, .inval_done, .flash_busy, .flash_done, .err_det, .err_site, .err_multi,
    .mchk_req, .err_correct, .line_reload_req, .dmiss_req, .push_buf_empty,
    .store_buf_empty, .dmiss_go);

// file: core_spr_model.sv
// Behavioural core issuing register moves to the cache control block.
// Assumes the bench calls its tasks; moves launch just after rising edges.
`timescale 1ns/1ps
module core_spr_model
    import l1_cache_pkg::*;
(
    input wire logic clk_sys,
    input wire logic inval_busy,
    input wire logic flash_busy,
    input wire logic spr_rvalid,
    input wire logic [31:0] spr_rdata,
    output logic [9:0] spr_num,
    output logic spr_wr,
    output logic [31:0] spr_wdata,
    output logic spr_rd
);
    // Idle bus at time zero
    initial {spr_num, spr_wr, spr_wdata, spr_rd} = 44'h0;

    // One write move; released lines show inverted data so stale values never match
    task automatic wr(input logic [9:0] n, input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (inval_busy === 1'b1) v[POS_INVAL] = 1'b0;
        if (flash_busy === 1'b1) v[POS_FLASH] = 1'b0;
        @(posedge clk_sys);
        spr_num <= n;
        spr_wdata <= v;
        spr_wr <= 1'b1;
        @(posedge clk_sys);
        spr_wr <= 1'b0;
        spr_wdata <= ~v;
        spr_num <= ~n;
    endtask

    // One read move; answer taken in the cycle after the read edge
    task automatic rd(input logic [9:0] n, output logic [31:0] d, output logic ok);
        @(posedge clk_sys);
        spr_num <= n;
        spr_rd <= 1'b1;
        @(posedge clk_sys);
        spr_rd <= 1'b0;
        spr_num <= ~n;
        #1;
        ok = spr_rvalid;
        d = spr_rdata;
    endtask
endmodule

// file: test_l1_icache_control_config.sv
// Self-checking bench for the level-one cache control block.
// Assumes the core model issues all moves; ce is held high throughout.
`timescale 1ns/1ps
module test_l1_icache_control_config import l1_cache_pkg::*; ;
    logic clk_sys = 1'b0, rstn = 1'b0, fill_wr = 1'b0, op_abort = 1'b0, lock_fail = 1'b0;
    logic lock_overflow = 1'b0, err_det = 1'b0, err_multi = 1'b0, err_line_locked = 1'b0;
    logic dmiss_req = 1'b0, push_buf_empty = 1'b1, store_buf_empty = 1'b1;
    logic [1:0] err_site = 2'h0;
    logic [9:0] spr_num;
    logic [31:0] spr_wdata, spr_rdata;
    logic spr_wr, spr_rd, spr_rvalid, icache_lookup_en, inval_busy, inval_done, flash_busy;
    logic flash_done, ovf_replace_locked, mchk_req, err_correct, line_inval_req;
    logic line_reload_req, dmiss_go, drain_req;
    logic [7:0] fill_par_invert;
    logic [1:0] fill_chk_invert, chk_type;
    int fails = 0;
    int checks_done = 0;

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    core_spr_model m (.clk_sys, .inval_busy, .flash_busy, .spr_rvalid, .spr_rdata, .spr_num,
        .spr_wr, .spr_wdata, .spr_rd);

    l1_icache_control_config uut (.clk_sys, .rstn, .ce(1'b1), .spr_num, .spr_wr, .spr_wdata,
        .spr_rd, .spr_rdata, .spr_rvalid, .fill_wr, .fill_par_invert, .fill_chk_invert,
        .icache_lookup_en, .chk_type, .inval_busy, .inval_done, .flash_busy, .flash_done,
        .op_abort, .lock_fail, .lock_overflow, .ovf_replace_locked, .err_det, .err_site,
        .err_multi, .err_line_locked, .mchk_req, .err_correct, .line_inval_req,
        .line_reload_req, .dmiss_req, .push_buf_empty, .store_buf_empty, .dmiss_go,
        .drain_req);

    // Shared comparison; case inequality so unknowns never match
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function logic [31:0] b(input int p);
        return 32'h1 << p;
    endfunction

    // Read a register and compare the answer
    task rdc(input logic [9:0] n, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        m.rd(n, d, ok);
        chk({31'h0, ok}, 32'h1);
        chk(d, exp);
    endtask

    task wrc(input logic [31:0] d);
        m.wr(SPR_ICACHE_CSR, d);
        #1;
    endtask

    task t_regs;
        rdc(SPR_ICACHE_CSR, 32'h0);
        chk(icache_lookup_en, 1'b0);
        rdc(SPR_DCACHE_CFG, 32'h2858_1810);
        rdc(SPR_ICACHE_CFG, 32'h0858_1810);
        rdc(10'h3F0, 32'h0);
        wrc(b(POS_ENABLE) | b(POS_OVF_ALLOC));
        chk({icache_lookup_en, ovf_replace_locked}, 2'h3);
        rdc(SPR_ICACHE_CSR, b(POS_ENABLE) | b(POS_OVF_ALLOC));
        wrc(32'h0);
        chk({icache_lookup_en, ovf_replace_locked}, 2'h0);
    endtask

    // Full sweep, with a zero write in mid-run that must be ignored
    task t_sweep(input logic fl);
        int n;
        logic [31:0] w;
        w = fl ? b(POS_FLASH) : (b(POS_INVAL) | b(POS_DTYPE_LO));
        wrc(w);
        n = 0;
        fork
            while ((fl ? flash_busy : inval_busy) === 1'b1 && n < 300) begin
                n++;
                @(posedge clk_sys);
                #1;
            end
            m.wr(SPR_ICACHE_CSR, w & ~(b(POS_FLASH) | b(POS_INVAL)));
        join
        chk(n, OP_CYCLES);
        if (n == 300) wrap_up;
        chk(fl ? flash_done : inval_done, 1'b1);
        chk(chk_type, w[POS_DTYPE_LO +: 2]);
        rdc(SPR_ICACHE_CSR, w & ~(b(POS_FLASH) | b(POS_INVAL)));
    endtask

    task t_abort;
        wrc(b(POS_FLASH));
        repeat (3) @(posedge clk_sys);
        op_abort <= 1'b1;
        @(posedge clk_sys);
        op_abort <= 1'b0;
        #1;
        chk({flash_busy, flash_done}, 2'h0);
        rdc(SPR_ICACHE_CSR, b(POS_ABORTED));
        wrc(32'h0);
        rdc(SPR_ICACHE_CSR, 32'h0);
    endtask

    task lock_ev(input logic f, input logic o, input logic [31:0] exp);
        @(posedge clk_sys);
        lock_fail <= f;
        lock_overflow <= o;
        @(posedge clk_sys);
        lock_fail <= 1'b0;
        lock_overflow <= 1'b0;
        rdc(SPR_ICACHE_CSR, exp);
    endtask

    task t_sticky;
        lock_ev(1'b1, 1'b1, b(POS_OVERFLOW));
        lock_ev(1'b1, 1'b0, b(POS_OVERFLOW) | b(POS_UNABLE));
        wrc(b(POS_UNABLE) | b(POS_OVERFLOW));
        rdc(SPR_ICACHE_CSR, b(POS_OVERFLOW) | b(POS_UNABLE));
        wrc(b(POS_UNABLE));
        rdc(SPR_ICACHE_CSR, b(POS_UNABLE));
        wrc(32'h0);
        rdc(SPR_ICACHE_CSR, 32'h0);
    endtask

    task fill(input logic [31:0] csr, input logic [9:0] exp);
        wrc(csr);
        @(posedge clk_sys);
        fill_wr <= 1'b1;
        @(posedge clk_sys);
        fill_wr <= 1'b0;
        #1;
        chk({fill_par_invert, fill_chk_invert}, exp);
    endtask

    task err(input logic [31:0] csr, input logic [1:0] s, input logic mu, input logic lk,
            input logic [3:0] exp);
        wrc(csr);
        @(posedge clk_sys);
        err_det <= 1'b1;
        err_site <= s;
        err_multi <= mu;
        err_line_locked <= lk;
        @(posedge clk_sys);
        err_det <= 1'b0;
        #1;
        chk({mchk_req, err_correct, line_inval_req, line_reload_req}, exp);
    endtask

    task miss(input logic r, input logic p, input logic s, input logic [1:0] exp);
        @(posedge clk_sys);
        dmiss_req <= r;
        push_buf_empty <= p;
        store_buf_empty <= s;
        #1;
        chk({dmiss_go, drain_req}, exp);
    endtask

    // Reset held three cycles, released through the design's two flops, defaults checked
    task t_reset;
        rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
    endtask

    initial begin
        t_reset();
        t_sweep(1'b0);
        t_sweep(1'b1);
        t_abort();
        t_sticky();
        fill(b(POS_INJECT), 10'h3FC);
        fill(b(POS_INJECT) | b(POS_DTYPE_LO), 10'h003);
        fill(b(POS_DTYPE_LO), 10'h000);
        err(32'h0, SITE_TAG, 1'b0, 1'b0, 4'h0);
        err(b(POS_CHECK_EN), SITE_TAG, 1'b0, 1'b0, 4'h8);
        err(b(POS_CHECK_EN) | b(POS_ACTION_LO), SITE_DATA, 1'b1, 1'b0, 4'h1);
        err(b(POS_CHECK_EN) | b(POS_ACTION_LO) | b(POS_DTYPE_LO), SITE_TAG, 1'b0, 1'b0,
            4'h4);
        err(b(POS_CHECK_EN) | b(POS_ACTION_LO) | b(POS_DTYPE_LO), SITE_LOCK, 1'b1, 1'b0,
            4'h2);
        err(b(POS_CHECK_EN) | b(POS_ACTION_LO), SITE_TAG, 1'b0, 1'b1, 4'hA);
        miss(1'b1, 1'b0, 1'b1, 2'h1);
        miss(1'b1, 1'b1, 1'b0, 2'h1);
        miss(1'b1, 1'b1, 1'b1, 2'h2);
        miss(1'b0, 1'b1, 1'b1, 2'h0);
        // Second reset in mid-run must drop a set enable
        wrc(b(POS_ENABLE));
        chk(icache_lookup_en, 1'b1);
        @(posedge clk_sys);
        t_reset();
        wrap_up();
    end
endmodule
